// *** hdl/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
module pin_sync
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pin,
	output logic level
);

	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			// a change counts only once the last two stages agree
			if (stage2 == stage3)
				level <= stage3;
		end
	end

endmodule : pin_sync

// *** hdl/timer0_shared_prescaler.sv ***
// 8-bit timer/counter with prescaler shared with the watchdog
// Summary of operation
// R1 - external timer clock sampled after prescaler on second and fourth phase clocks
// R2 - prescaler given to watchdog: pin clock feeds the synchroniser directly
// R3 - option bit 7 set disables all pull-ups, clear uses each pin latch
// R4 - option bit 6 set: external interrupt on rising edge, clear: falling
// R5 - option bit 5 set: count pin transitions, clear: instruction clock
// R6 - option bit 4 set: count falling pin edges, clear: rising edges
// R7 - option bit 3 set: prescaler to watchdog, clear: prescaler to timer
// R8 - rate codes 000-111 give timer 1:2..1:256, watchdog 1:1..1:128
// R9 - one 8-bit counter serves as timer prescaler or watchdog postscaler
// R10 - prescaler counter has no software read or write path
// R11 - any timer count write clears prescaler while it belongs to timer
// R12 - clear-watchdog clears watchdog and prescaler while it belongs to watchdog
// R13 - assignment may change any time by writing the option register
// R14 - software sequence for moving prescaler from timer to watchdog
// R15 - software clears watchdog before moving prescaler back to timer
// R16 - option register at 81h, resets to all ones
// R17 - timer increments suppressed two instruction cycles after a count write
// R18 - count wrap from FFh to 00h sets the overflow flag
// R19 - flag cleared only by software; enable bit masks the interrupt
// R20 - timer stops during sleep so overflow cannot wake
// R21 - at most one increment per instruction cycle, after the prescaler
// R22 - watchdog ticks pass through the prescaler to the watchdog reset logic
`include "timer0_params.svh"

module timer0_shared_prescaler
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic timer_ext_clock_pin,
	input wire logic ext_interrupt_pin,
	input wire logic [5:0] port_pullup_latch,
	input wire logic sleep_mode,
	input wire logic clear_watchdog,
	input wire logic watchdog_tick,
	output logic [5:0] pullup_enable,
	output logic timer_irq,
	output logic ext_irq_event,
	output logic watchdog_clear,
	output logic watchdog_postscaled_tick
);

	// timer prescale output: bit (rate) toggles, rising every 2^(rate+1) inputs
	function automatic logic prescale_tap(input logic [7:0] count, input timer0_pkg::rate_t rate);
		prescale_tap = count[rate];
	endfunction : prescale_tap

	// watchdog postscale: low (rate) bits all ones marks the last of 2^rate ticks
	function automatic logic [7:0] rate_mask(input timer0_pkg::rate_t rate);
		rate_mask = 8'((9'h001 << rate) - 9'h001);
	endfunction : rate_mask

	timer0_pkg::phase_t phase;
	timer0_pkg::phase_t next_phase;

	timer0_pkg::byte_t timer_count;
	timer0_pkg::byte_t interrupt_control;
	timer0_pkg::byte_t option_settings;
	timer0_pkg::byte_t port_a_direction;

	logic [7:0] prescaler;
	logic [1:0] write_inhibit;
	logic src_level_d;
	logic sampled_level;
	logic rise_pending;
	logic irq_src_d;

	wire logic [1:0] pin_raw;
	wire logic [1:0] pin_level;

	assign pin_raw = {ext_interrupt_pin, timer_ext_clock_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			pin_sync u_sync
			(
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.pin(pin_raw[gi]),
				.level(pin_level[gi])
			);
		end
	endgenerate

	// option and interrupt-control fields
	wire logic port_pullup_disable;
	wire logic ext_irq_edge_select;
	wire logic timer_clock_source_sel;
	wire logic timer_source_edge_sel;
	wire logic prescaler_assign;
	wire timer0_pkg::rate_t prescale_rate_field;
	wire logic timer_overflow_enable;
	wire logic timer_overflow_flag;

	assign port_pullup_disable = option_settings[`BIT_PULLUP_DISABLE];
	assign ext_irq_edge_select = option_settings[`BIT_IRQ_EDGE];
	assign timer_clock_source_sel = option_settings[`BIT_CLOCK_SOURCE];
	assign timer_source_edge_sel = option_settings[`BIT_SOURCE_EDGE];
	assign prescaler_assign = option_settings[`BIT_PRESCALER_ASSIGN];
	assign prescale_rate_field = option_settings[`BIT_RATE_HI:`BIT_RATE_LO];
	assign timer_overflow_enable = interrupt_control[`BIT_OVERFLOW_ENABLE];
	assign timer_overflow_flag = interrupt_control[`BIT_OVERFLOW_FLAG];

	// register decode
	wire logic hit_timer;
	wire logic hit_interrupt_control;
	wire logic hit_option;
	wire logic hit_direction;
	wire logic write_timer;
	wire logic write_interrupt_control;
	wire logic write_option;
	wire logic write_direction;

	assign hit_timer = (reg_addr == `ADDR_TIMER_COUNT);
	assign hit_interrupt_control = (reg_addr == `ADDR_INTERRUPT_CONTROL)
		| (reg_addr == `ADDR_INTERRUPT_CONTROL_ALT);
	assign hit_option = (reg_addr == `ADDR_OPTION_SETTINGS); // R16
	assign hit_direction = (reg_addr == `ADDR_PORT_A_DIRECTION);
	assign write_timer = reg_wr & hit_timer;
	assign write_interrupt_control = reg_wr & hit_interrupt_control;
	assign write_option = reg_wr & hit_option; // R13
	assign write_direction = reg_wr & hit_direction;

	// prescaler is absent from the read map
	wire timer0_pkg::byte_t read_mux;

	assign read_mux = hit_timer ? timer_count
		: hit_interrupt_control ? interrupt_control
		: hit_option ? option_settings
		: hit_direction ? (port_a_direction & `MASK_PORT_A_DIRECTION)
		: `READ_UNMAPPED; // R10

	// four phase clocks make one instruction cycle
	always_comb
	begin
		case (phase)
			timer0_pkg::phase_q1: next_phase = timer0_pkg::phase_q2;
			timer0_pkg::phase_q2: next_phase = timer0_pkg::phase_q3;
			timer0_pkg::phase_q3: next_phase = timer0_pkg::phase_q4;
			timer0_pkg::phase_q4: next_phase = timer0_pkg::phase_q1;
			default: next_phase = timer0_pkg::phase_q1;
		endcase
	end

	wire logic q2_strobe;
	wire logic q4_strobe;
	wire logic cycle_end;

	assign q2_strobe = (phase == timer0_pkg::phase_q2);
	assign q4_strobe = (phase == timer0_pkg::phase_q4);
	assign cycle_end = q4_strobe;

	// edge-selected external source: invert so the counted edge is always a rise
	wire logic src_level;
	wire logic src_rise;

	assign src_level = pin_level[0] ^ timer_source_edge_sel; // R6
	assign src_rise = src_level & ~src_level_d;

	// shared prescaler input and clear
	wire logic prescaler_on_timer;
	wire logic timer_source_pulse;
	wire logic prescaler_inc;
	wire logic prescaler_clear;

	assign prescaler_on_timer = ~prescaler_assign; // R7 R9
	assign timer_source_pulse = timer_clock_source_sel ? src_rise : cycle_end; // R5
	assign prescaler_inc = prescaler_on_timer ? (timer_source_pulse & ~sleep_mode)
		: watchdog_tick; // R20 R22
	assign prescaler_clear = (write_timer & prescaler_on_timer)
		| (clear_watchdog & prescaler_assign); // R11 R12

	// synchroniser input: prescaler output, or the pin itself when unassigned
	wire logic sampler_input;
	wire logic sample_strobe;
	wire logic sample_rise;

	assign sampler_input = prescaler_on_timer
		? prescale_tap(prescaler, prescale_rate_field)
		: src_level; // R2 R8
	assign sample_strobe = q2_strobe | q4_strobe; // R1
	assign sample_rise = sample_strobe & sampler_input & ~sampled_level; // R1

	// one increment request per instruction cycle
	wire logic direct_internal;
	wire logic inc_request;
	wire logic timer_increment;
	wire logic timer_wrap;

	assign direct_internal = ~timer_clock_source_sel & prescaler_assign;
	assign inc_request = direct_internal | rise_pending | sample_rise; // R21
	assign timer_increment = cycle_end & inc_request & ~sleep_mode
		& (write_inhibit == 2'h0) & ~write_timer; // R17 R20 R21
	assign timer_wrap = timer_increment & (timer_count == `TIMER_MAX); // R18

	// watchdog postscaler output, straight through when the prescaler is elsewhere
	wire logic postscale_done;
	wire logic watchdog_out;

	assign postscale_done = ((prescaler & rate_mask(prescale_rate_field))
		== rate_mask(prescale_rate_field)); // R8
	assign watchdog_out = watchdog_tick & (prescaler_on_timer | postscale_done); // R22

	// external interrupt edge
	wire logic irq_src;
	wire logic irq_rise;

	assign irq_src = pin_level[1] ~^ ext_irq_edge_select; // R4
	assign irq_rise = irq_src & ~irq_src_d;

	// next register values; hardware sets win over software clears
	wire timer0_pkg::byte_t next_timer_count;
	wire timer0_pkg::byte_t next_interrupt_control;
	wire timer0_pkg::byte_t interrupt_control_set;
	wire logic [1:0] next_inhibit;
	wire logic [5:0] next_pullup;
	wire logic next_timer_irq;

	assign next_timer_count = write_timer ? reg_wdata
		: timer_increment ? 8'(timer_count + 8'h01)
		: timer_count;
	assign interrupt_control_set = 8'({timer_wrap, 2'h0} | {irq_rise, 1'h0}); // R18
	assign next_interrupt_control = (write_interrupt_control ? reg_wdata : interrupt_control)
		| interrupt_control_set; // R19
	assign next_inhibit = write_timer ? `WRITE_INHIBIT_CYCLES
		: (cycle_end & (write_inhibit != 2'h0)) ? 2'(write_inhibit - 2'h1)
		: write_inhibit; // R17
	assign next_pullup = port_pullup_disable ? 6'h00 : port_pullup_latch; // R3
	assign next_timer_irq = next_interrupt_control[`BIT_OVERFLOW_FLAG]
		& next_interrupt_control[`BIT_OVERFLOW_ENABLE]; // R19

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			phase <= timer0_pkg::phase_q1;
		else
			phase <= next_phase;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer_count <= `RESET_TIMER_COUNT;
			interrupt_control <= `RESET_INTERRUPT_CONTROL;
			write_inhibit <= 2'h0;
		end
		else
		begin
			timer_count <= next_timer_count;
			interrupt_control <= next_interrupt_control;
			write_inhibit <= next_inhibit;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			option_settings <= `RESET_OPTION_SETTINGS; // R16
			port_a_direction <= `RESET_PORT_A_DIRECTION;
		end
		else
		begin
			if (write_option)
				option_settings <= reg_wdata; // R13
			if (write_direction)
				port_a_direction <= reg_wdata & `MASK_PORT_A_DIRECTION;
		end
	end

	// the single shared counter
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prescaler <= 8'h00;
		else if (prescaler_clear)
			prescaler <= 8'h00; // R11 R12
		else if (prescaler_inc)
			prescaler <= 8'(prescaler + 8'h01); // R9
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// reset edge select inverts the low pin, so the idle source level is high
			src_level_d <= 1'b1;
			irq_src_d <= 1'b0;
		end
		else
		begin
			src_level_d <= src_level;
			irq_src_d <= irq_src;
		end
	end

	// phase-clock sampler and pending rise held to the cycle end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// matches the idle sampler input so no false count follows reset
			sampled_level <= 1'b1;
			rise_pending <= 1'b0;
		end
		else
		begin
			if (sample_strobe)
				sampled_level <= sampler_input; // R1
			if (cycle_end)
				rise_pending <= 1'b0; // R21
			else if (sample_rise)
				rise_pending <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_rdata <= 8'h00;
			pullup_enable <= 6'h00;
			timer_irq <= 1'b0;
			ext_irq_event <= 1'b0;
			watchdog_clear <= 1'b0;
			watchdog_postscaled_tick <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? read_mux : 8'h00;
			pullup_enable <= next_pullup; // R3
			timer_irq <= next_timer_irq; // R19
			ext_irq_event <= irq_rise; // R4
			watchdog_clear <= clear_watchdog; // R12
			watchdog_postscaled_tick <= watchdog_out; // R22
		end
	end

endmodule : timer0_shared_prescaler

// *** include/timer0_params.svh ***
// addresses, field positions, reset values and counts of the timer block
`ifndef TIMER0_PARAMS_SVH
`define TIMER0_PARAMS_SVH

`define ADDR_TIMER_COUNT 8'h01
`define ADDR_INTERRUPT_CONTROL 8'h0b
`define ADDR_INTERRUPT_CONTROL_ALT 8'h8b
`define ADDR_OPTION_SETTINGS 8'h81
`define ADDR_PORT_A_DIRECTION 8'h85

`define RESET_TIMER_COUNT 8'h00
`define RESET_INTERRUPT_CONTROL 8'h00
`define RESET_OPTION_SETTINGS 8'hff
`define RESET_PORT_A_DIRECTION 8'h3f
`define MASK_PORT_A_DIRECTION 8'h3f
`define READ_UNMAPPED 8'h00

`define BIT_PULLUP_DISABLE 7
`define BIT_IRQ_EDGE 6
`define BIT_CLOCK_SOURCE 5
`define BIT_SOURCE_EDGE 4
`define BIT_PRESCALER_ASSIGN 3
`define BIT_RATE_HI 2
`define BIT_RATE_LO 0

`define BIT_OVERFLOW_ENABLE 5
`define BIT_OVERFLOW_FLAG 2
`define BIT_EXT_IRQ_FLAG 1

`define TIMER_MAX 8'hff
`define WRITE_INHIBIT_CYCLES 2'h2
`define PORT_A_PINS 6

`endif

// *** include/timer0_pkg.sv ***
// types shared by the timer block
package timer0_pkg;

	typedef enum logic [3:0]
	{
		phase_q1 = 4'h1,
		phase_q2 = 4'h2,
		phase_q3 = 4'h4,
		phase_q4 = 4'h8
	} phase_t;

	typedef logic [2:0] rate_t;

	typedef logic [7:0] byte_t;

endpackage : timer0_pkg

// *** verification/ext_clk_src.sv ***
// model of the external clock source on the timer pin
module ext_clk_src
(
	input wire logic clk_sys,
	input wire logic start,
	input wire logic [7:0] pulses,
	input wire logic [3:0] half,
	output logic pin,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// pin rests low between bursts, edges land off the clock edge
	initial
	begin
		pin = 1'b0;
		busy = 1'b0;
		forever
		begin
			@(posedge clk_sys);
			if (start)
			begin
				busy = 1'b1;
				repeat (2 * pulses)
				begin
					repeat (half) @(posedge clk_sys);
					#3 pin = ~pin;
				end
				busy = 1'b0;
			end
		end
	end
endmodule : ext_clk_src

// *** verification/tb_top.sv ***
// self-checking bench for the timer block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {string name; logic [7:0] exp;} note_t;
	logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pulses = 8'h0a, reg_rdata;
	logic ext_interrupt_pin = 1'b0, sleep_mode = 1'b0, clear_watchdog = 1'b0;
	logic watchdog_tick = 1'b0, start = 1'b0, pin, busy;
	logic [5:0] port_pullup_latch = 6'h00, pullup_enable;
	logic [3:0] half = 4'h6;
	logic timer_irq, ext_irq_event, watchdog_clear, wd_out;
	int bad_count = 0, samples_checked = 0, cyc = 0, ticks = 0, irqs = 0, w;
	note_t q[$];
	note_t n;
	ext_clk_src src (.clk_sys, .start, .pulses, .half, .pin, .busy);
	timer0_shared_prescaler dut
	(
		.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.timer_ext_clock_pin(pin), .ext_interrupt_pin, .port_pullup_latch, .sleep_mode,
		.clear_watchdog, .watchdog_tick, .pullup_enable, .timer_irq, .ext_irq_event,
		.watchdog_clear, .watchdog_postscaled_tick(wd_out)
	);
	always #5 clk_sys = ~clk_sys;
	task automatic check(input string name, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// result monitor: read data stands in the cycle after the strobe
	always @(posedge clk_sys)
	begin
		cyc <= rst_b ? cyc + 1 : 0;
		ticks <= ticks + int'(wd_out);
		irqs <= irqs + int'(ext_irq_event);
		port_pullup_latch <= 6'($urandom);
		rd_seen <= reg_rd;
		if (rd_seen)
		begin
			n = q.pop_front();
			check(n.name, reg_rdata, n.exp);
		end
		if (cyc > 20000)
		begin
			bad_count++;
			end_sim();
		end
	end
	task automatic bus(input logic wr, input logic [7:0] a, d);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic rd(input string name, input logic [7:0] a, exp);
		q.push_back('{name, exp});
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic tick(input int k);
		repeat (k)
		begin
			watchdog_tick <= 1'b1;
			@(posedge clk_sys);
			watchdog_tick <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask : tick
	task automatic wclr();
		clear_watchdog <= 1'b1;
		@(posedge clk_sys);
		clear_watchdog <= 1'b0;
		@(posedge clk_sys);
	endtask : wclr
	initial
	begin
		w = $urandom(33);
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd("option", 8'h81, 8'hff);
		rd("interrupt_control", 8'h0b, 8'h00);
		bus(1'b1, 8'h85, 8'hff);
		rd("direction", 8'h85, 8'h3f);
		rd("unmapped", 8'h55, 8'h00);
		bus(1'b1, 8'h81, 8'h08);
		bus(1'b1, 8'h0b, 8'h20);
		// write lands on a first-phase edge so the count is exact
		while (cyc % 4 != 3) @(posedge clk_sys);
		bus(1'b1, 8'h01, 8'hfa);
		repeat (39) @(posedge clk_sys);
		rd("count", 8'h01, 8'h02);
		check("irq", {7'h00, timer_irq}, 8'h01);
		repeat (100) @(posedge clk_sys);
		rd("interrupt_control", 8'h0b, 8'h24);
		bus(1'b1, 8'h0b, 8'h04);
		check("irq masked", {7'h00, timer_irq}, 8'h00);
		bus(1'b1, 8'h0b, 8'h00);
		sleep_mode <= 1'b1;
		bus(1'b1, 8'h01, 8'h40);
		repeat (200) @(posedge clk_sys);
		rd("sleep count", 8'h01, 8'h40);
		sleep_mode <= 1'b0;
		for (int r = 2; r < 8; r++)
		begin
			bus(1'b1, 8'h81, 8'(r));
			bus(1'b1, 8'h01, 8'h10);
			repeat ((16 << r) - 2) @(posedge clk_sys);
			rd("scaled count", 8'h01, 8'h12);
		end
		wclr();
		bus(1'b1, 8'h01, 8'h00);
		for (int r = 0; r < 4; r++)
		begin
			bus(1'b1, 8'h81, 8'(8 + r));
			wclr();
			w = ticks;
			tick(16);
			check("wd ticks", 8'(ticks - w), 8'(16 >> r));
		end
		bus(1'b1, 8'h81, 8'h09);
		w = ticks;
		tick(1);
		wclr();
		tick(3);
		check("wd cleared", 8'(ticks - w), 8'h01);
		bus(1'b1, 8'h81, 8'h00);
		w = ticks;
		tick(4);
		check("wd direct", 8'(ticks - w), 8'h04);
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, 8'h81, i == 0 ? 8'h28 : i == 1 ? 8'h38 : 8'h20);
			bus(1'b1, 8'h01, 8'h00);
			half <= i == 1 ? 4'hc : 4'h6;
			repeat (8) @(posedge clk_sys);
			start <= 1'b1;
			@(posedge clk_sys);
			start <= 1'b0;
			repeat (3) @(posedge clk_sys);
			for (int k = 0; k < 1000 && busy; k++) @(posedge clk_sys);
			repeat (20) @(posedge clk_sys);
			rd("pin count", 8'h01, i == 2 ? 8'h05 : 8'h0a);
		end
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, 8'h81, i == 0 ? 8'h08 : 8'h48);
			repeat (10) @(posedge clk_sys);
			w = irqs;
			repeat (3)
			begin
				ext_interrupt_pin <= ~ext_interrupt_pin;
				repeat (20) @(posedge clk_sys);
			end
			check("edge events", 8'(irqs - w), 8'h01);
		end
		end_sim();
	end
endmodule : tb_top

// *** verification/timer0_chk.sv ***
// port assertions for the timer block
module timer0_chk
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic ext_interrupt_pin,
	input wire logic [5:0] port_pullup_latch,
	input wire logic clear_watchdog,
	input wire logic watchdog_tick,
	input wire logic [5:0] pullup_enable,
	input wire logic ext_irq_event,
	input wire logic watchdog_clear,
	input wire logic watchdog_postscaled_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] opt;
	wire opt_wr = reg_wr && reg_addr == 8'h81;
	// shadow of the option register
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			opt <= 8'hff;
		else if (opt_wr)
			opt <= reg_wdata;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence pin_edge_s;
		opt[6] ? $rose(ext_interrupt_pin) : $fell(ext_interrupt_pin);
	endsequence
	sequence irq_seen_s;
		##[1:8] ext_irq_event;
	endsequence
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	opt_read_a: assert property (reg_rd && reg_addr == 8'h81 |=> reg_rdata == $past(opt))
		else $error("option read mismatch");
	pullup_a: assert property (pullup_enable == ($past(opt[7]) ? 6'h00 : $past(port_pullup_latch)))
		else $error("pull-up enables wrong");
	wd_clear_a: assert property (clear_watchdog |=> watchdog_clear)
		else $error("watchdog clear not passed");
	wd_direct_a: assert property ((!opt[3] || opt[2:0] == 3'h0) && watchdog_tick |=> watchdog_postscaled_tick)
		else $error("watchdog tick not passed");
	wd_src_a: assert property (watchdog_postscaled_tick |-> $past(watchdog_tick))
		else $error("watchdog output without tick");
	irq_pulse_a: assert property (ext_irq_event |=> !ext_irq_event)
		else $error("edge event too long");
	irq_edge_a: assert property (pin_edge_s |-> irq_seen_s)
		else $error("selected edge gave no event");
endmodule : timer0_chk
bind timer0_shared_prescaler timer0_chk chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .ext_interrupt_pin, .port_pullup_latch, .clear_watchdog, .watchdog_tick,
	.pullup_enable, .ext_irq_event, .watchdog_clear, .watchdog_postscaled_tick);
